// *** bench/pmv_core_sva.sv ***
// Checker for the on/off and voltage configuration block
`timescale 1ns/100ps
module pmv_core_sva
    import pmv_pkg::*;
(
    input wire logic        CLK,
    input wire logic        NRST,
    input wire logic        POWER_PRESENT,
    input wire logic        CMD_VALID,
    input wire logic [1:0]  CMD_KIND,
    input wire logic [7:0]  CMD_CODE,
    input wire logic [15:0] RDATA,
    input wire logic        RDATA_VALID,
    input wire logic        CMD_NAK,
    input wire logic        BUSY,
    input wire logic        OUTPUT_ENABLE,
    input wire logic [15:0] TARGET_VOLTAGE,
    input wire logic [7:0]  SECURITY_LEVEL
);
    // ----------------
    // Command and output checks
    // ----------------
    // Commands count as taken only while idle
    wire logic rq = CMD_VALID && !BUSY && CMD_KIND == KIND_READ;
    wire logic wq = CMD_VALID && !BUSY && CMD_KIND == KIND_WRITE;
    wire logic sq = CMD_VALID && !BUSY && CMD_KIND == KIND_SEND;
    default clocking @(posedge CLK); endclocking
    default disable iff (!NRST);
    chk_busy_refuse: assert property (CMD_VALID && BUSY |=> CMD_NAK)
        else $error("command taken while busy");
    chk_fmt_read: assert property (rq && CMD_CODE == CODE_VFORMAT
        |=> RDATA_VALID && RDATA == {8'h00, VFMT_MODE, VFMT_EXPONENT}) else $error("format byte wrong");
    chk_fmt_readonly: assert property (wq && CMD_CODE == CODE_VFORMAT |=> CMD_NAK)
        else $error("format byte write not refused");
    chk_set_answer: assert property (rq && CMD_CODE == CODE_SETPOINT |=> RDATA_VALID && !CMD_NAK)
        else $error("setpoint read not answered");
    chk_restore_level: assert property (sq && CMD_CODE == CODE_RESTORE_USER
        |=> SECURITY_LEVEL == SECURITY_USER ##1 BUSY) else $error("restore did not set level");
    chk_store_hold: assert property (sq && CMD_CODE == CODE_STORE_USER |=> ##1 BUSY [*3])
        else $error("store without hold-off");
    chk_target_ceiling: assert property (RDATA_VALID && $past(CMD_CODE) == CODE_CEILING
        |-> TARGET_VOLTAGE <= RDATA) else $error("target above ceiling");
    chk_power_off: assert property (!POWER_PRESENT |=> !OUTPUT_ENABLE)
        else $error("running without power");
endmodule

// *** bench/pmv_host.sv ***
// Host model issuing one command at a time on the command port
`timescale 1ns/100ps
module pmv_host
    import pmv_pkg::*;
(
    input wire logic        CLK,
    input wire logic        BUSY,
    input wire logic        go,
    input wire logic        raw,
    input wire logic [25:0] req,
    output logic            CMD_VALID,
    output logic     [1:0]  CMD_KIND,
    output logic     [7:0]  CMD_CODE,
    output logic     [15:0] CMD_WDATA
);
    // ----------
    // Issuing
    // ----------
    initial {CMD_VALID, CMD_KIND, CMD_CODE, CMD_WDATA} = '0;
    // Waits out the hold-off unless told to break it; idle data toggles so stale values never match
    always @(posedge CLK) begin
        CMD_VALID <= 1'b0;
        if (go && !CMD_VALID && (raw || !BUSY)) begin
            CMD_VALID <= 1'b1;
            {CMD_KIND, CMD_CODE, CMD_WDATA} <= req;
        end else begin
            CMD_WDATA <= ~CMD_WDATA;
        end
    end
endmodule

// *** bench/testbench.sv ***
// Self-checking bench for the on/off and voltage configuration block
`timescale 1ns/100ps
module testbench;
    import pmv_pkg::*;
    // ----------
    // Signals
    // ----------
    logic        CLK = 1'b0, NRST = 1'b0, POWER_PRESENT = 1'b1, CONTROL_PIN = 1'b0, go = 1'b0, raw = 1'b0, nk;
    logic [7:0]  FAULT_EVENTS = 8'h00;
    logic [25:0] req = '0;
    logic [15:0] rd;
    int          error_cnt = 0, cmp_count = 0;
    wire logic        CMD_VALID, RDATA_VALID, CMD_NAK, BUSY, OUTPUT_ENABLE, OFF_SOFT, OFF_FAST;
    wire logic [1:0]  CMD_KIND;
    wire logic [7:0]  CMD_CODE, FAULT_STATUS, SECURITY_LEVEL;
    wire logic [15:0] CMD_WDATA, RDATA, TARGET_VOLTAGE, SLEW_RATE;
    // Short hold-off keeps the run brief
    pmv_core #(.BUSY_CYCLES(21'd20)) u_pmv_core (.CLK, .NRST, .POWER_PRESENT, .CONTROL_PIN, .FAULT_EVENTS,
        .VOLTAGE_SELECT_STRAP(16'h0100), .CMD_VALID, .CMD_KIND, .CMD_CODE, .CMD_WDATA, .RDATA, .RDATA_VALID,
        .CMD_NAK, .BUSY, .OUTPUT_ENABLE, .OFF_SOFT, .OFF_FAST, .TARGET_VOLTAGE, .SLEW_RATE, .FAULT_STATUS,
        .SECURITY_LEVEL);
    pmv_host u_pmv_host (.CLK, .BUSY, .go, .raw, .req, .CMD_VALID, .CMD_KIND, .CMD_CODE, .CMD_WDATA);
    always #5 CLK = ~CLK;
    // ----------
    // Tasks
    // ----------
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic end_of_test;
        $display("errors=%0d compares=%0d", error_cnt, cmp_count);
        if (error_cnt == 0 && cmp_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // One command; returns once its settings show at the outputs
    task automatic cmd(input logic [25:0] r, input logic b = 1'b0);
        @(posedge CLK);
        go <= 1'b1;
        raw <= b;
        req <= r;
        for (int i = 0; i < 99 && CMD_VALID !== 1'b1; i++) @(posedge CLK);
        go <= 1'b0;
        if (CMD_VALID !== 1'b1) begin
            error_cnt++;
            $display("BAD t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
            end_of_test();
        end else begin
            #1 rd = RDATA;
            nk = CMD_NAK;
            @(posedge CLK);
            #1;
        end
    endtask
    task automatic t_defaults;
        logic [23:0] v [6] = '{24'h200014, 24'h020016, 24'h210100, 24'h240119, 24'h25010c, 24'h2600f4};
        foreach (v[i]) begin
            cmd({KIND_READ, v[i][23:16], 16'h0000});
            chk(rd, v[i][15:0]);
        end
        chk(16'(SECURITY_LEVEL), 16'h0001);
    endtask
    // Fields: on/off, OPERATION, pin/power, expected run/soft/fast
    task automatic t_run;
        logic [23:0] v [10] = '{24'h000014, 24'h000001, 24'h1e8034, 24'h1e8012, 24'h1f8011,
                                24'h1c8014, 24'h1e4032, 24'h1e0031, 24'h160034, 24'h1a8014};
        foreach (v[i]) begin
            cmd({KIND_WRITE, CODE_ON_OFF_CFG, 8'h00, v[i][23:16]});
            cmd({KIND_WRITE, CODE_OPERATION, 8'h00, v[i][15:8]});
            @(posedge CLK);
            CONTROL_PIN <= v[i][5];
            POWER_PRESENT <= v[i][4];
            @(posedge CLK);
            #1 chk(16'(v[i][2] ? {OUTPUT_ENABLE, 2'b00} : {OUTPUT_ENABLE, OFF_SOFT, OFF_FAST}), 16'(v[i][2:0]));
        end
    endtask
    // Fields: code, data, expected target
    task automatic t_target;
        logic [39:0] s [8] = '{40'h2100800080, 40'h2200100090, 40'h23fff80088, 40'h01009000fc,
                               40'h0100a00114, 40'h2401100110, 40'h24ffff0114, 40'h2701230114};
        foreach (s[i]) begin
            cmd({KIND_WRITE, s[i][39:16]});
            chk(TARGET_VOLTAGE, s[i][15:0]);
        end
        chk(SLEW_RATE, 16'h0123);
        cmd({KIND_READ, CODE_CEILING, 16'h0000});
        chk(rd, 16'h0119);
    endtask
    task automatic t_fault;
        @(posedge CLK);
        FAULT_EVENTS <= 8'h5a;
        @(posedge CLK);
        FAULT_EVENTS <= 8'h00;
        cmd({KIND_SEND, CODE_OPERATION, 16'h0000});
        chk(16'(FAULT_STATUS), 16'h005a);
        cmd({KIND_SEND, CODE_CLEAR_FLT, 16'h0000});
        chk(16'(FAULT_STATUS), 16'h0000);
        cmd({KIND_WRITE, CODE_VFORMAT, 16'h0000});
        chk(16'(nk), 16'h0001);
    endtask
    task automatic t_store;
        cmd({KIND_SEND, CODE_STORE_DFLT, 16'h0000});
        cmd({KIND_WRITE, CODE_SETPOINT, 16'h0055});
        cmd({KIND_SEND, CODE_RESTORE_DFLT, 16'h0000});
        cmd({KIND_READ, CODE_SETPOINT, 16'h0000});
        chk(rd, 16'h0080);
        cmd({KIND_SEND, CODE_RESTORE_USER, 16'h0000});
        cmd({KIND_WRITE, CODE_SETPOINT, 16'h0077});
        cmd({KIND_SEND, CODE_STORE_USER, 16'h0000});
        cmd({KIND_READ, CODE_SETPOINT, 16'h0000}, 1'b1);
        chk(16'(nk), 16'h0001);
        cmd({KIND_WRITE, CODE_SETPOINT, 16'h0066});
        cmd({KIND_WRITE, CODE_TRIM, 16'h0001});
        cmd({KIND_SEND, CODE_RESTORE_USER, 16'h0000});
        cmd({KIND_READ, CODE_SETPOINT, 16'h0000});
        chk(rd, 16'h0077);
        cmd({KIND_READ, CODE_TRIM, 16'h0000});
        chk(rd, 16'h0001);
    endtask
    // Reset for five cycles, then every scenario in turn
    initial begin
        repeat (5) @(posedge CLK);
        NRST <= 1'b1;
        t_defaults();
        t_run();
        t_target();
        t_fault();
        t_store();
        end_of_test();
    end
endmodule
bind pmv_core pmv_core_sva u_pmv_core_sva (.CLK, .NRST, .POWER_PRESENT, .CMD_VALID, .CMD_KIND, .CMD_CODE,
    .RDATA, .RDATA_VALID, .CMD_NAK, .BUSY, .OUTPUT_ENABLE, .TARGET_VOLTAGE, .SECURITY_LEVEL);

// *** inc/pmv_pkg.sv ***
// Constants and types shared by the output control and voltage configuration block
package pmv_pkg;

    // ------------------------------------------------------------------
    // Command codes
    // ------------------------------------------------------------------
    localparam logic [7:0] CODE_OPERATION   = 8'h01;
    localparam logic [7:0] CODE_ON_OFF_CFG  = 8'h02;
    localparam logic [7:0] CODE_CLEAR_FLT   = 8'h03;
    localparam logic [7:0] CODE_STORE_DFLT  = 8'h11;
    localparam logic [7:0] CODE_RESTORE_DFLT = 8'h12;
    localparam logic [7:0] CODE_STORE_USER  = 8'h15;
    localparam logic [7:0] CODE_RESTORE_USER = 8'h16;
    localparam logic [7:0] CODE_VFORMAT     = 8'h20;
    localparam logic [7:0] CODE_SETPOINT    = 8'h21;
    localparam logic [7:0] CODE_TRIM        = 8'h22;
    localparam logic [7:0] CODE_CAL_OFFSET  = 8'h23;
    localparam logic [7:0] CODE_CEILING     = 8'h24;
    localparam logic [7:0] CODE_MARGIN_HIGH = 8'h25;
    localparam logic [7:0] CODE_MARGIN_LOW  = 8'h26;
    localparam logic [7:0] CODE_SLEW_RATE   = 8'h27;

    // ------------------------------------------------------------------
    // Command kinds on the decoded command port
    // ------------------------------------------------------------------
    localparam logic [1:0] KIND_SEND  = 2'h0;
    localparam logic [1:0] KIND_WRITE = 2'h1;
    localparam logic [1:0] KIND_READ  = 2'h2;

    // ------------------------------------------------------------------
    // Configuration slots (index into the setting array)
    // ------------------------------------------------------------------
    localparam int          NUM_SLOTS   = 9;
    localparam logic [3:0] SLOT_OP      = 4'h0;
    localparam logic [3:0] SLOT_ONOFF   = 4'h1;
    localparam logic [3:0] SLOT_SET     = 4'h2;
    localparam logic [3:0] SLOT_TRIM    = 4'h3;
    localparam logic [3:0] SLOT_CAL     = 4'h4;
    localparam logic [3:0] SLOT_CEIL    = 4'h5;
    localparam logic [3:0] SLOT_MHIGH   = 4'h6;
    localparam logic [3:0] SLOT_MLOW    = 4'h7;
    localparam logic [3:0] SLOT_SLEW    = 4'h8;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int ONOFF_PWRUP_BIT  = 4;
    localparam int ONOFF_BUS_BIT    = 3;
    localparam int ONOFF_PIN_BIT    = 2;
    localparam int ONOFF_POL_BIT    = 1;
    localparam int ONOFF_ACTION_BIT = 0;
    localparam int OP_ENABLE_HI     = 7;
    localparam int OP_ENABLE_LO     = 6;
    localparam int OP_MARGIN_HI     = 5;
    localparam int OP_MARGIN_LO     = 4;

    localparam logic [1:0] EN_IMMEDIATE_OFF = 2'h0;
    localparam logic [1:0] EN_SOFT_OFF      = 2'h1;
    localparam logic [1:0] EN_ON            = 2'h2;
    localparam logic [1:0] MARGIN_NOMINAL   = 2'h0;
    localparam logic [1:0] MARGIN_LOW       = 2'h1;
    localparam logic [1:0] MARGIN_HIGH      = 2'h2;

    // ------------------------------------------------------------------
    // Voltage format byte and reset values
    // ------------------------------------------------------------------
    localparam logic [2:0] VFMT_LINEAR   = 3'h0;
    localparam logic [2:0] VFMT_VID      = 3'h1;
    localparam logic [2:0] VFMT_DIRECT   = 3'h2;
    localparam logic [2:0] VFMT_MODE     = VFMT_LINEAR;
    localparam logic [4:0] VFMT_EXPONENT = 5'h14;
    localparam logic [15:0] OP_RESET     = 16'h0000;
    localparam logic [15:0] ONOFF_RESET  = 16'h0016;
    localparam logic [15:0] SLEW_RESET   = 16'h0000;
    localparam logic [7:0] SECURITY_RESET = 8'h00;
    localparam logic [7:0] SECURITY_USER  = 8'h01;
    localparam logic [7:0] MARGIN_DIV     = 8'h14;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int CLK_HZ       = 100_000_000;
    localparam int BUSY_TIME_MS = 20;
    localparam int BUSY_CYCLES_DFLT = BUSY_TIME_MS * (CLK_HZ / 1000);

    typedef enum logic [2:0] {
        ST_STRAP = 3'b001,
        ST_BUSY  = 3'b010,
        ST_RUN   = 3'b100
    } pmv_phase_t;

    typedef struct packed {
        pmv_phase_t                   phase;
        logic [15:0]                  strap;
        logic [NUM_SLOTS-1:0][15:0]   cfg;
        logic [NUM_SLOTS-1:0][15:0]   dflt;
        logic [NUM_SLOTS-1:0][15:0]   user;
        logic [NUM_SLOTS-1:0]         dirty;
        logic [NUM_SLOTS-1:0]         uvalid;
        logic                         dvalid;
        logic [7:0]                   faults;
        logic [7:0]                   security;
        logic [20:0]                  busy_cnt;
        logic                         busy;
        logic [15:0]                  rdata;
        logic                         rvalid;
        logic                         nak;
        logic                         out_en;
        logic                         off_soft;
        logic                         off_fast;
        logic [15:0]                  target;
        logic [15:0]                  slew;
    } pmv_state_t;

endpackage

// *** logic/pmv_core.sv ***
// Output on/off decision, fault clearing, configuration stores and voltage settings
`timescale 1ns/100ps
module pmv_core
    import pmv_pkg::*;
#(
    parameter logic [20:0] BUSY_CYCLES = 21'(BUSY_CYCLES_DFLT)
) (
    input  wire logic        CLK,
    input  wire logic        NRST,
    input  wire logic        POWER_PRESENT,
    input  wire logic        CONTROL_PIN,
    input  wire logic [15:0] VOLTAGE_SELECT_STRAP,
    input  wire logic [7:0]  FAULT_EVENTS,
    input  wire logic        CMD_VALID,
    input  wire logic [1:0]  CMD_KIND,
    input  wire logic [7:0]  CMD_CODE,
    input  wire logic [15:0] CMD_WDATA,
    output logic      [15:0] RDATA,
    output logic             RDATA_VALID,
    output logic             CMD_NAK,
    output logic             BUSY,
    output logic             OUTPUT_ENABLE,
    output logic             OFF_SOFT,
    output logic             OFF_FAST,
    output logic      [15:0] TARGET_VOLTAGE,
    output logic      [15:0] SLEW_RATE,
    output logic      [7:0]  FAULT_STATUS,
    output logic      [7:0]  SECURITY_LEVEL
);

    // ------------------------------------------------------------------
    // State and helpers
    // ------------------------------------------------------------------
    pmv_state_t s;
    pmv_state_t next_s;

    // Map a command code onto a setting slot
    function automatic logic [4:0] slot_of(input logic [7:0] code);
        logic [4:0] r;
        r = 5'h00;
        case (code)
            CODE_OPERATION:   r = {1'b1, SLOT_OP};
            CODE_ON_OFF_CFG:  r = {1'b1, SLOT_ONOFF};
            CODE_SETPOINT:    r = {1'b1, SLOT_SET};
            CODE_TRIM:        r = {1'b1, SLOT_TRIM};
            CODE_CAL_OFFSET:  r = {1'b1, SLOT_CAL};
            CODE_CEILING:     r = {1'b1, SLOT_CEIL};
            CODE_MARGIN_HIGH: r = {1'b1, SLOT_MHIGH};
            CODE_MARGIN_LOW:  r = {1'b1, SLOT_MLOW};
            CODE_SLEW_RATE:   r = {1'b1, SLOT_SLEW};
            default:          r = 5'h00;
        endcase
        return r;
    endfunction

    // Byte-wide settings keep only the low byte; upper bits read as zero
    function automatic logic [15:0] fit(input logic [3:0] slot, input logic [15:0] d);
        logic [15:0] r;
        r = d;
        if (slot == SLOT_OP || slot == SLOT_ONOFF) begin
            r = {8'h00, d[7:0]};
        end
        return r;
    endfunction

    // ------------------------------------------------------------------
    // Strap-derived limits and defaults
    // ------------------------------------------------------------------
    logic [19:0] strap_x11;
    logic [15:0] ceil_limit;
    logic [15:0] margin_step;
    logic [15:0] ml_dflt;

    // Ceiling limit is 110% of the strap; saturates rather than wrapping
    assign strap_x11   = 20'(s.strap) * 20'd11;
    assign ceil_limit  = (strap_x11 / 20'd10) > 20'h0ffff ? 16'hffff : 16'((strap_x11 / 20'd10));
    assign margin_step = s.strap / 16'(MARGIN_DIV);
    assign ml_dflt     = s.strap - margin_step;

    // ------------------------------------------------------------------
    // Run decision and target voltage
    // ------------------------------------------------------------------
    logic        pin_asserted;
    logic        pin_mode;
    logic        bus_mode;
    logic        pin_says_off;
    logic [1:0]  en_field;
    logic [1:0]  mg_field;
    logic        run;
    logic [15:0] base;
    logic signed [18:0] trimmed;
    logic [15:0] clamped;

    assign pin_asserted = s.cfg[SLOT_ONOFF][ONOFF_POL_BIT] ? CONTROL_PIN : ~CONTROL_PIN;
    assign pin_mode     = s.cfg[SLOT_ONOFF][ONOFF_PIN_BIT];
    assign bus_mode     = s.cfg[SLOT_ONOFF][ONOFF_BUS_BIT];
    assign en_field     = s.cfg[SLOT_OP][OP_ENABLE_HI:OP_ENABLE_LO];
    assign mg_field     = s.cfg[SLOT_OP][OP_MARGIN_HI:OP_MARGIN_LO];
    assign pin_says_off = pin_mode && !pin_asserted;

    // Outputs stay off only during strap capture; run can rise in the same cycle the power-up restore lands
    always_comb begin
        run = 1'b0;
        if (s.phase != ST_STRAP && POWER_PRESENT) begin
            if (!s.cfg[SLOT_ONOFF][ONOFF_PWRUP_BIT]) begin
                run = 1'b1;
            end else begin
                run = (!bus_mode || en_field == EN_ON)
                   && !pin_says_off;
            end
        end
    end

    // Select the target by margin field, add both offsets, then clamp
    always_comb begin
        case (mg_field)
            MARGIN_LOW:  base = s.cfg[SLOT_MLOW];
            MARGIN_HIGH: base = s.cfg[SLOT_MHIGH];
            default:     base = s.cfg[SLOT_SET];
        endcase
        trimmed = $signed({3'b000, base})
                + 19'(signed'(s.cfg[SLOT_TRIM]))
                + 19'(signed'(s.cfg[SLOT_CAL]));
        if (trimmed < 0) begin
            clamped = 16'h0000;
        end else if (trimmed > $signed({3'b000, s.cfg[SLOT_CEIL]})) begin
            clamped = s.cfg[SLOT_CEIL];
        end else begin
            clamped = trimmed[15:0];
        end
    end

    // ------------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------------
    logic [4:0] hit;
    logic       take;

    assign hit  = slot_of(CMD_CODE);
    assign take = CMD_VALID && s.phase == ST_RUN;

    always_comb begin
        next_s          = s;
        next_s.rvalid   = 1'b0;
        next_s.nak      = 1'b0;

        // Phase sequencing: strap capture, power-up restore, busy wait
        case (s.phase)
            ST_STRAP: begin
                next_s.strap            = VOLTAGE_SELECT_STRAP;
                next_s.cfg[SLOT_OP]     = OP_RESET;
                next_s.cfg[SLOT_ONOFF]  = ONOFF_RESET;
                next_s.cfg[SLOT_SET]    = VOLTAGE_SELECT_STRAP;
                next_s.cfg[SLOT_TRIM]   = 16'h0000;
                next_s.cfg[SLOT_CAL]    = 16'h0000;
                next_s.cfg[SLOT_CEIL]   = 16'hffff;
                next_s.cfg[SLOT_MHIGH]  = VOLTAGE_SELECT_STRAP;
                next_s.cfg[SLOT_MLOW]   = VOLTAGE_SELECT_STRAP;
                next_s.cfg[SLOT_SLEW]   = SLEW_RESET;
                next_s.phase            = ST_BUSY;
                next_s.busy_cnt         = BUSY_CYCLES;
            end
            ST_BUSY: begin
                if (s.busy_cnt == 21'h000000) begin
                    next_s.phase = ST_RUN;
                end else begin
                    next_s.busy_cnt = s.busy_cnt - 21'h000001;
                end
            end
            ST_RUN: begin
                next_s.phase = ST_RUN;
            end
            default: begin
                next_s.phase = ST_STRAP;
            end
        endcase

        // Strap defaults need the captured strap, so they land one cycle later,
        // followed by the automatic user restore over them
        if (s.phase == ST_BUSY && s.busy_cnt == BUSY_CYCLES) begin
            next_s.cfg[SLOT_CEIL]  = ceil_limit;
            next_s.cfg[SLOT_MHIGH] = s.strap + margin_step;
            next_s.cfg[SLOT_MLOW]  = ml_dflt;
            for (int i = 0; i < NUM_SLOTS; i++) begin
                if (s.uvalid[i]) begin
                    next_s.cfg[i] = s.user[i];
                end
            end
            next_s.dirty    = '0;
            next_s.security = SECURITY_USER;
        end

        // Commands are refused while a store or restore is still settling
        if (CMD_VALID && s.phase != ST_RUN) begin
            next_s.nak = 1'b1;
        end

        if (take) begin
            case (CMD_KIND)
                KIND_WRITE: begin
                    if (hit[4]) begin
                        next_s.cfg[hit[3:0]]   = fit(hit[3:0], CMD_WDATA);
                        next_s.dirty[hit[3:0]] = 1'b1;
                        if (hit[3:0] == SLOT_CEIL && CMD_WDATA > ceil_limit) begin
                            next_s.cfg[SLOT_CEIL] = ceil_limit;
                        end
                    end else begin
                        next_s.nak = 1'b1;                                 // format byte is read-only
                    end
                end
                KIND_READ: begin
                    next_s.rvalid = 1'b1;
                    if (hit[4]) begin
                        next_s.rdata = s.cfg[hit[3:0]];
                    end else if (CMD_CODE == CODE_VFORMAT) begin
                        next_s.rdata = {8'h00, VFMT_MODE,
                            (VFMT_MODE == VFMT_DIRECT) ? 5'h00 : VFMT_EXPONENT};
                    end else begin
                        next_s.rdata  = 16'h0000;
                        next_s.rvalid = 1'b0;
                        next_s.nak    = 1'b1;
                    end
                end
                KIND_SEND: begin
                    case (CMD_CODE)
                        CODE_CLEAR_FLT: begin
                            next_s.faults = 8'h00;
                        end
                        CODE_STORE_DFLT: begin
                            next_s.dflt   = s.cfg;
                            next_s.dvalid = 1'b1;
                        end
                        CODE_RESTORE_DFLT: begin
                            if (s.dvalid) begin
                                next_s.cfg = s.dflt;
                            end
                            next_s.dirty = '0;
                        end
                        CODE_STORE_USER: begin
                            for (int i = 0; i < NUM_SLOTS; i++) begin
                                if (s.dirty[i]) begin
                                    next_s.user[i]   = s.cfg[i];
                                    next_s.uvalid[i] = 1'b1;
                                end
                            end
                            next_s.phase    = ST_BUSY;
                            next_s.busy_cnt = BUSY_CYCLES - 21'h000001;
                        end
                        CODE_RESTORE_USER: begin
                            for (int i = 0; i < NUM_SLOTS; i++) begin
                                if (s.uvalid[i]) begin
                                    next_s.cfg[i] = s.user[i];
                                end
                            end
                            next_s.dirty    = '0;
                            next_s.security = SECURITY_USER;
                            next_s.phase    = ST_BUSY;
                            next_s.busy_cnt = BUSY_CYCLES - 21'h000001;
                        end
                        default: begin
                            next_s.nak = 1'b1;
                        end
                    endcase
                end
                default: begin
                    next_s.nak = 1'b1;
                end
            endcase
        end

        // Busy follows the new phase, so a low BUSY always means commands are taken
        next_s.busy = next_s.phase != ST_RUN;

        // Fault events set after any clear, so a simultaneous event survives
        next_s.faults = next_s.faults | FAULT_EVENTS;

        // Output control and off style
        next_s.out_en   = run;
        next_s.off_soft = 1'b0;
        next_s.off_fast = 1'b0;
        if (!run) begin
            if (!POWER_PRESENT || s.phase == ST_STRAP) begin
                next_s.off_fast = 1'b1;
            end else if (s.cfg[SLOT_ONOFF][ONOFF_PWRUP_BIT] && pin_says_off) begin
                next_s.off_fast = s.cfg[SLOT_ONOFF][ONOFF_ACTION_BIT];
                next_s.off_soft = !s.cfg[SLOT_ONOFF][ONOFF_ACTION_BIT];
            end else begin
                next_s.off_fast = en_field == EN_IMMEDIATE_OFF;
                next_s.off_soft = en_field != EN_IMMEDIATE_OFF;
            end
        end
        next_s.target = clamped;
        next_s.slew   = s.cfg[SLOT_SLEW];
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    // Stores are cleared by reset; a real part keeps them in non-volatile cells
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            s          <= '0;
            s.phase    <= ST_STRAP;
            s.busy     <= 1'b1;
            s.off_fast <= 1'b1;
            s.security <= SECURITY_RESET;
        end else begin
            s <= next_s;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign RDATA          = s.rdata;
    assign RDATA_VALID    = s.rvalid;
    assign CMD_NAK        = s.nak;
    assign BUSY           = s.busy;
    assign OUTPUT_ENABLE  = s.out_en;
    assign OFF_SOFT       = s.off_soft;
    assign OFF_FAST       = s.off_fast;
    assign TARGET_VOLTAGE = s.target;
    assign SLEW_RATE      = s.slew;
    assign FAULT_STATUS   = s.faults;
    assign SECURITY_LEVEL = s.security;

endmodule
